// ---- hdl/blc_core.sv ----
// Frame sequencer, register file and pixel correction of the dark-level calibration block.
`timescale 1ns/1ps
`default_nettype none
`include "blc_map.svh"
module blc_core #(
  parameter int PIX_W   = 10,
  parameter int PATHS   = 8,
  parameter int DEPTH_W = 3,
  parameter int LINE_W  = 8
) (
  input  wire logic                   core_clk,
  input  wire logic                   reset,
  input  wire blc_pkg::reg_addr_t     reg_addr,
  input  wire blc_pkg::reg_word_t     reg_wdata,
  input  wire logic                   reg_wr,
  output blc_pkg::reg_word_t          reg_rd_data,
  input  wire logic                   frame_start,
  input  wire logic                   rolling_shutter,
  input  wire logic [LINE_W-1:0]      rs_line_kernels,
  input  wire logic                   in_valid,
  input  wire logic [PATHS*PIX_W-1:0] in_data,
  output logic                        dark_row_active,
  output logic                        out_valid,
  output logic                        out_dark,
  output logic [PATHS*PIX_W-1:0]      out_data
);
  import blc_pkg::*;

  blc_calib_if cal ();

  reg_word_t          dark_filter_config;
  reg_word_t          level_correction_ctrl;
  reg_word_t          dark_row_config;
  logic [PATHS-1:0]   dark_sample_shortfall_flags;
  phase_t             state;
  logic [7:0]         act_lines;
  logic               act_skip;
  logic [DEPTH_W-1:0] act_depth;
  logic               act_auto;
  logic [8:0]         act_offset;
  logic               act_dec;
  logic               act_rolling;
  logic [LINE_W-1:0]  act_line_len;
  logic [LINE_W-1:0]  kernel_cnt;
  logic [7:0]         line_cnt;
  logic               first_line;
  logic               line_end;
  logic               dark_end;
  logic               finish_q;
  logic               take;
  logic               in_dark;
  wire logic [PATHS*PIX_W-1:0] next_data;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      dark_filter_config    <= `RST_DARK_FILTER_CONFIG;
      level_correction_ctrl <= `RST_LEVEL_CORR_CTRL;
      dark_row_config       <= `RST_DARK_ROW_CONFIG;
    end else if (reg_wr) begin
      case (reg_addr)
        `REG_DARK_FILTER_CONFIG: dark_filter_config    <= reg_wdata;
        `REG_LEVEL_CORR_CTRL:    level_correction_ctrl <= reg_wdata;
        `REG_DARK_ROW_CONFIG:    dark_row_config       <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Unmapped addresses read as zero; the shortfall flags are read-only.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      reg_rd_data <= 16'h0000;
    end else begin
      case (reg_addr)
        `REG_DARK_FILTER_CONFIG: reg_rd_data <= dark_filter_config;
        `REG_LEVEL_CORR_CTRL:    reg_rd_data <= level_correction_ctrl;
        `REG_DARK_ROW_CONFIG:    reg_rd_data <= dark_row_config;
        `REG_DARK_SHORTFALL:     reg_rd_data <= 16'(dark_sample_shortfall_flags);
        default:                 reg_rd_data <= 16'h0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Active settings, frozen for the whole frame
  // ----------------------------------------------------------------
  // Register writes land in the staging copies at any time; the datapath
  // only ever sees the snapshot taken at frame start, so a frame is never
  // processed with a half-updated configuration.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      act_lines    <= 8'h01;
      act_skip     <= 1'b0;
      act_depth    <= '0;
      act_auto     <= 1'b0;
      act_offset   <= 9'h000;
      act_dec      <= 1'b0;
      act_rolling  <= 1'b0;
      act_line_len <= `GS_LINE_KERNELS;
    end else if (frame_start) begin
      act_lines    <= dark_row_config[`ROW_LINES_MSB:`ROW_LINES_LSB];
      act_skip     <= dark_row_config[`ROW_SKIP_BIT];
      act_depth    <= dark_filter_config[`FILT_DEPTH_MSB:`FILT_DEPTH_LSB];
      act_auto     <= level_correction_ctrl[`CTRL_AUTO_BIT];
      act_offset   <= level_correction_ctrl[`CTRL_OFFSET_MSB:`CTRL_OFFSET_LSB];
      act_dec      <= level_correction_ctrl[`CTRL_DEC_BIT];
      act_rolling  <= rolling_shutter;
      act_line_len <= rolling_shutter ? rs_line_kernels : `GS_LINE_KERNELS;
    end
  end

  // ----------------------------------------------------------------
  // Dark line sequencer
  // ----------------------------------------------------------------
  assign in_dark    = (state == ST_DARK);
  assign first_line = act_skip && (line_cnt == 8'h00);
  assign line_end   = in_dark && in_valid && (kernel_cnt == LINE_W'(act_line_len - 1'b1));
  assign dark_end   = line_end && (line_cnt == 8'(act_lines - 8'h01));

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state           <= ST_IDLE;
      dark_row_active <= 1'b0;
    end else if (frame_start) begin
      state           <= ST_DARK;
      dark_row_active <= 1'b1;
    end else if (dark_end) begin
      state           <= ST_IMAGE;
      dark_row_active <= 1'b0;
    end
  end

  // One input beat carries one kernel: eight adjacent columns, one per path.
  always_ff @(posedge core_clk) begin
    if (reset || frame_start) begin
      kernel_cnt <= '0;
      line_cnt   <= 8'h00;
    end else if (line_end) begin
      kernel_cnt <= '0;
      line_cnt   <= 8'(line_cnt + 8'h01);
    end else if (in_dark && in_valid) begin
      kernel_cnt <= LINE_W'(kernel_cnt + 1'b1);
    end
  end

  // Only even kernels feed the statistics, halving the available samples.
  assign take = act_auto && in_dark && in_valid && !first_line && !kernel_cnt[0];

  always_ff @(posedge core_clk) begin
    if (reset) begin
      finish_q <= 1'b0;
    end else begin
      finish_q <= dark_end && act_auto;
    end
  end

  assign cal.clear  = frame_start;
  assign cal.take   = take;
  assign cal.finish = finish_q;
  assign cal.depth  = act_depth;

  // ----------------------------------------------------------------
  // Per-path filter and correction
  // ----------------------------------------------------------------
  for (genvar p = 0; p < PATHS; p++) begin : g_path
    logic [PIX_W-1:0] pix;
    logic [PIX_W-1:0] level;
    logic [PIX_W-1:0] amount;
    logic             sub;
    logic [PIX_W:0]   sum_ext;
    logic [PIX_W:0]   dif_ext;

    assign pix = in_data[p*PIX_W +: PIX_W];

    dark_accum #(
      .PIX_W   (PIX_W),
      .DEPTH_W (DEPTH_W)
    ) u_accum (
      .core_clk   (core_clk),
      .reset      (reset),
      .cal        (cal),
      .sample     (pix),
      .level      (level),
      .short_flag (dark_sample_shortfall_flags[p])
    );

    // Auto mode always subtracts its own level; the sign bit is ignored there.
    assign amount  = act_auto ? level : PIX_W'(act_offset);
    assign sub     = act_auto || act_dec;
    assign sum_ext = {1'b0, pix} + {1'b0, amount};
    assign dif_ext = {1'b0, pix} - {1'b0, amount};

    assign next_data[p*PIX_W +: PIX_W] =
      in_dark ? pix :
      sub ? (dif_ext[PIX_W] ? '0 : dif_ext[PIX_W-1:0]) :
      (sum_ext[PIX_W] ? {PIX_W{1'b1}} : sum_ext[PIX_W-1:0]);
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      out_valid <= 1'b0;
      out_dark  <= 1'b0;
      out_data  <= '0;
    end else begin
      out_valid <= in_valid && !(in_dark && first_line);
      out_dark  <= in_dark;
      out_data  <= next_data;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence s_last_dark_beat;
    dark_end && act_auto;
  endsequence
  sequence s_filter_done;
    cal.finish ##1 (state == ST_IMAGE);
  endsequence

  a_frame_dark_start: assert property (frame_start |=> in_dark && dark_row_active)
    else $error("Frame did not open with dark lines.");
  a_gs_line_len: assert property (in_dark && !act_rolling |-> act_line_len == 8'hA0)
    else $error("Global shutter dark line length wrong.");
  a_rs_line_len: assert property (frame_start && rolling_shutter |=>
    act_line_len == $past(rs_line_kernels)) else $error("Rolling line length wrong.");
  a_skip_blank: assert property (in_dark && first_line && in_valid && !frame_start |=>
    !out_valid && !$past(take)) else $error("First dark line not blanked.");
  a_auto_gate: assert property (!act_auto |-> !take)
    else $error("Samples taken with automatic mode off.");
  a_dark_raw: assert property (in_dark && in_valid && !first_line |=>
    out_valid && out_dark && out_data == $past(in_data)) else $error("Dark sample altered.");
  a_manual_add: assert property (!in_dark && in_valid && !act_auto && !act_dec &&
    ({1'b0, in_data[PIX_W-1:0]} + 11'(act_offset)) <= 11'h3FF |=>
    out_data[PIX_W-1:0] == PIX_W'($past(in_data[PIX_W-1:0]) + $past(act_offset)))
    else $error("Manual offset not added.");
  a_sat_zero: assert property (!in_dark && in_valid && !act_auto && act_dec &&
    in_data[PIX_W-1:0] < PIX_W'(act_offset) |=> out_data[PIX_W-1:0] == '0)
    else $error("Subtraction wrapped.");
  a_half_kernels: assert property (take |-> !kernel_cnt[0])
    else $error("Odd kernel used for statistics.");
  a_cfg_frozen: assert property (!frame_start |=> $stable(act_depth) && $stable(act_lines)
    && $stable(act_offset)) else $error("Settings changed mid-frame.");
  a_frame_filter: assert property (s_last_dark_beat |=> s_filter_done)
    else $error("Dark level not refreshed at end of dark lines.");
  a_dark_row_end: assert property (dark_end && !frame_start |=> !dark_row_active)
    else $error("Dark phase did not end after the last dark line.");
  a_line_bound: assert property (in_dark && (act_lines != 8'h00) |->
    line_cnt < act_lines) else $error("Dark line count ran past the programmed count.");
  a_kernel_bound: assert property (in_dark && (act_line_len != '0) |->
    kernel_cnt < act_line_len) else $error("Kernel count ran past the line length.");
  a_stats_restart: assert property (frame_start |=> g_path[0].u_accum.count == '0)
    else $error("Statistics not restarted at frame start.");
  a_flags_hold: assert property (!finish_q |=> $stable(dark_sample_shortfall_flags))
    else $error("Shortfall flags changed outside the end of dark lines.");
  a_status_read: assert property (reg_addr == `REG_DARK_SHORTFALL |=>
    reg_rd_data == 16'($past(dark_sample_shortfall_flags))) else $error("Shortfall read wrong.");

  // ----------------------------------------------------------------
  // Datapath checks
  // ----------------------------------------------------------------
  // Path 0 and the last path stand for all paths, which share one generate body.
  a_auto_sub: assert property (!in_dark && in_valid && act_auto &&
    in_data[PIX_W-1:0] >= g_path[0].level |=>
    out_data[PIX_W-1:0] == PIX_W'($past(in_data[PIX_W-1:0]) - $past(g_path[0].level)))
    else $error("Dark level not subtracted.");
  a_sat_full: assert property (!in_dark && in_valid && !act_auto && !act_dec &&
    ({1'b0, in_data[PATHS*PIX_W-1 -: PIX_W]} + 11'(act_offset)) > 11'h3FF |=>
    out_data[PATHS*PIX_W-1 -: PIX_W] == {PIX_W{1'b1}}) else $error("Addition wrapped.");
  a_manual_last: assert property (!in_dark && in_valid && !act_auto && !act_dec &&
    ({1'b0, in_data[PATHS*PIX_W-1 -: PIX_W]} + 11'(act_offset)) <= 11'h3FF |=>
    out_data[PATHS*PIX_W-1 -: PIX_W] ==
    PIX_W'($past(in_data[PATHS*PIX_W-1 -: PIX_W]) + $past(act_offset)))
    else $error("Last path used another offset.");
endmodule
`default_nettype wire

// ---- hdl/blc_map.svh ----
// Register offsets, field positions, reset values and counts of the dark-level calibration block.
`ifndef BLC_MAP_SVH
`define BLC_MAP_SVH

// ----------------------------------------------------------------
// Register offsets (9-bit register address space)
// ----------------------------------------------------------------
`define REG_DARK_FILTER_CONFIG  9'h080
`define REG_LEVEL_CORR_CTRL     9'h081
`define REG_DARK_SHORTFALL      9'h088
`define REG_DARK_ROW_CONFIG     9'h0C5

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define FILT_DEPTH_LSB          8
`define FILT_DEPTH_MSB          10
`define CTRL_AUTO_BIT           0
`define CTRL_OFFSET_LSB         1
`define CTRL_OFFSET_MSB         9
`define CTRL_DEC_BIT            10
`define ROW_LINES_LSB           0
`define ROW_LINES_MSB           7
`define ROW_SKIP_BIT            8

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define RST_DARK_FILTER_CONFIG  16'h0300
`define RST_LEVEL_CORR_CTRL     16'h0001
`define RST_DARK_ROW_CONFIG     16'h0104
`define GS_LINE_KERNELS         8'hA0

`endif

// ---- hdl/blc_pkg.sv ----
// Types shared by the dark-level calibration block.
package blc_pkg;
  typedef logic [8:0]  reg_addr_t;
  typedef logic [15:0] reg_word_t;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_DARK  = 2'b01,
    ST_IMAGE = 2'b11
  } phase_t;
endpackage

// ---- hdl/blc_calib_if.sv ----
// Control bundle from the frame sequencer to the per-path dark accumulators.
`timescale 1ns/1ps
`default_nettype none
interface blc_calib_if;
  logic       clear;
  logic       take;
  logic       finish;
  logic [2:0] depth;
  modport ctrl (output clear, output take, output finish, output depth);
  modport acc  (input clear, input take, input finish, input depth);
endinterface
`default_nettype wire

// ---- hdl/dark_accum.sv ----
// Per-path dark sample accumulator and low-pass filter.
`timescale 1ns/1ps
`default_nettype none
`include "blc_map.svh"
module dark_accum #(
  parameter int PIX_W   = 10,
  parameter int DEPTH_W = 3
) (
  input  wire logic             core_clk,
  input  wire logic             reset,
  blc_calib_if.acc              cal,
  input  wire logic [PIX_W-1:0] sample,
  output logic      [PIX_W-1:0] level,
  output logic                  short_flag
);
  import blc_pkg::*;

  localparam int CNT_W = (1 << DEPTH_W);
  localparam int SUM_W = PIX_W + CNT_W;

  logic [SUM_W-1:0] sum;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] target;

  // ----------------------------------------------------------------
  // Accumulation
  // ----------------------------------------------------------------
  assign target = CNT_W'(1) << cal.depth;

  always_ff @(posedge core_clk) begin
    if (reset || cal.clear) begin
      sum   <= '0;
      count <= '0;
    end else if (cal.take && (count < target)) begin
      sum   <= SUM_W'(sum + SUM_W'(sample));
      count <= CNT_W'(count + 1'b1);
    end
  end

  // The mean is a plain shift, so only power-of-two depths are offered.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      level      <= '0;
      short_flag <= 1'b0;
    end else if (cal.finish) begin
      level      <= PIX_W'(sum >> cal.depth);
      short_flag <= (count < target);
    end
  end

  a_count_capped: assert property (@(posedge core_clk) disable iff (reset)
    count <= target) else $error("Accumulator took more samples than requested.");
  a_short_report: assert property (@(posedge core_clk) disable iff (reset)
    cal.finish && (count < target) |=> short_flag)
    else $error("Shortfall not reported.");
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
// Self-checking testbench of the dark-level calibration block.
`timescale 1ns/1ps
`default_nettype none
`include "blc_map.svh"
module testbench;
  import blc_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and observation
  // ----------------------------------------------------------------
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  reg_addr_t   reg_addr = '0;
  reg_word_t   reg_wdata = '0;
  logic        reg_wr = 1'b0;
  reg_word_t   reg_rd_data;
  logic        frame_start = 1'b0;
  logic        rolling_shutter = 1'b0;
  logic [7:0]  rs_line_kernels = 8'h00;
  logic        in_valid = 1'b0;
  logic [79:0] in_data = '0;
  logic        dark_row_active;
  logic        out_valid;
  logic        out_dark;
  logic [79:0] out_data;
  int          n_errors = 0;
  int          tests_run = 0;
  always #4 core_clk = ~core_clk;
  blc_core dut (
    .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd_data(reg_rd_data), .frame_start(frame_start),
    .rolling_shutter(rolling_shutter), .rs_line_kernels(rs_line_kernels),
    .in_valid(in_valid), .in_data(in_data), .dark_row_active(dark_row_active),
    .out_valid(out_valid), .out_dark(out_dark), .out_data(out_data)
  );
  // ----------------------------------------------------------------
  // Shared tasks and expected-value arithmetic
  // ----------------------------------------------------------------
  task automatic check(input logic [79:0] seen, input logic [79:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input reg_addr_t a, input reg_word_t d);
    @(negedge core_clk);
    reg_addr = a; reg_wdata = d; reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input reg_addr_t a, input reg_word_t exp);
    @(negedge core_clk);
    reg_addr = a;
    @(negedge core_clk);
    check(80'(reg_rd_data), 80'(exp), "register read");
  endtask
  function automatic logic [79:0] mk(input int base, input int step);
    logic [79:0] w;
    for (int p = 0; p < 8; p++) w[p*10+:10] = 10'(base + p*step);
    return w;
  endfunction
  // Signed offset applied per path, clamped to the ten-bit output range.
  function automatic logic [79:0] adj(input logic [79:0] img, input logic [79:0] sub_w,
                                      input int off, input bit minus);
    logic [79:0] w;
    int          v;
    for (int p = 0; p < 8; p++) begin
      v = int'(img[p*10+:10]) + (minus ? -(off + int'(sub_w[p*10+:10])) : off);
      w[p*10+:10] = (v < 0) ? 10'h000 : (v > 1023) ? 10'h3FF : 10'(v);
    end
    return w;
  endfunction
  task automatic start_frame(input int nlines, input int len, input bit skip,
                             input logic [79:0] first_d, input logic [79:0] d);
    @(negedge core_clk);
    frame_start = 1'b1;
    @(negedge core_clk);
    frame_start = 1'b0;
    for (int l = 0; l < nlines; l++) begin
      for (int k = 0; k < len; k++) begin
        check(80'(dark_row_active), 80'd1, "dark phase");
        in_valid = 1'b1;
        in_data = (l == 0) ? first_d : d;
        @(negedge core_clk);
        check(80'(out_valid), 80'(!(skip && l == 0)), "dark beat valid");
        if (!(skip && l == 0)) begin
          check(80'(out_dark), 80'd1, "dark flag");
          check(out_data, in_data, "raw dark");
        end
      end
    end
    in_valid = 1'b0;
    repeat (3) @(negedge core_clk);
    check(80'(dark_row_active), 80'd0, "dark phase over");
  endtask
  task automatic img(input int n, input logic [79:0] d, input logic [79:0] e);
    for (int k = 0; k < n; k++) begin
      in_valid = 1'b1;
      in_data = d;
      @(negedge core_clk);
      check(80'({out_valid, out_dark}), 80'b10, "image beat");
      check(out_data, e, "image pixels");
    end
    in_valid = 1'b0;
    @(negedge core_clk);
  endtask
  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(negedge core_clk);
    reset = 1'b0;
    rd(`REG_DARK_FILTER_CONFIG, `RST_DARK_FILTER_CONFIG);
    rd(`REG_LEVEL_CORR_CTRL, `RST_LEVEL_CORR_CTRL);
    rd(`REG_DARK_ROW_CONFIG, `RST_DARK_ROW_CONFIG);
    rd(`REG_DARK_SHORTFALL, 16'h0000);
    wr(9'h0C6, 16'hBEEF);
    rd(9'h0C6, 16'h0000);
    wr(`REG_DARK_SHORTFALL, 16'h00FF);
    rd(`REG_DARK_SHORTFALL, 16'h0000);
    $display("test registers done");
    // Manual add of the largest offset, with saturation at full scale.
    wr(`REG_LEVEL_CORR_CTRL, 16'h03FE);
    rd(`REG_LEVEL_CORR_CTRL, 16'h03FE);
    wr(`REG_DARK_ROW_CONFIG, 16'h0001);
    start_frame(1, 160, 0, mk(5, 7), mk(5, 7));
    img(3, mk(0, 128), adj(mk(0, 128), '0, 511, 0));
    $display("test manual add done");
    // Manual subtract; a write in mid-frame must wait for the next frame.
    wr(`REG_LEVEL_CORR_CTRL, 16'h07FE);
    start_frame(1, 160, 0, mk(9, 3), mk(9, 3));
    img(2, mk(0, 128), adj(mk(0, 128), '0, 511, 1));
    wr(`REG_LEVEL_CORR_CTRL, 16'h000A);
    img(2, mk(0, 128), adj(mk(0, 128), '0, 511, 1));
    start_frame(1, 160, 0, mk(9, 3), mk(9, 3));
    img(2, mk(0, 128), adj(mk(0, 128), '0, 5, 0));
    $display("test manual subtract done");
    // Automatic mode with skip and the sign bit clear, so the level must still be subtracted;
    // the blanked line carries bright values that must not count.
    wr(`REG_DARK_FILTER_CONFIG, 16'h0200);
    wr(`REG_LEVEL_CORR_CTRL, 16'h0001);
    wr(`REG_DARK_ROW_CONFIG, 16'h0102);
    start_frame(2, 160, 1, mk(1023, 0), mk(16, 1));
    img(3, mk(256, 16), adj(mk(256, 16), mk(16, 1), 0, 1));
    img(1, mk(8, 1), 80'h0);
    rd(`REG_DARK_SHORTFALL, 16'h0000);
    $display("test automatic skip done");
    // Shortfall: 160 kernels give 80 samples per path, so depth 7 fails and 6 does not.
    wr(`REG_DARK_FILTER_CONFIG, 16'h0700);
    wr(`REG_DARK_ROW_CONFIG, 16'h0001);
    start_frame(1, 160, 0, mk(32, 0), mk(32, 0));
    rd(`REG_DARK_SHORTFALL, 16'h00FF);
    wr(`REG_DARK_FILTER_CONFIG, 16'h0600);
    start_frame(1, 160, 0, mk(40, 2), mk(40, 2));
    rd(`REG_DARK_SHORTFALL, 16'h0000);
    img(2, mk(600, 3), adj(mk(600, 3), mk(40, 2), 0, 1));
    $display("test shortfall global done");
    // Rolling shutter: three lines of 20 kernels give 30 samples per path.
    rolling_shutter = 1'b1;
    rs_line_kernels = 8'd20;
    wr(`REG_DARK_FILTER_CONFIG, 16'h0500);
    wr(`REG_DARK_ROW_CONFIG, 16'h0003);
    start_frame(3, 20, 0, mk(24, 0), mk(24, 0));
    rd(`REG_DARK_SHORTFALL, 16'h00FF);
    wr(`REG_DARK_FILTER_CONFIG, 16'h0400);
    start_frame(3, 20, 0, mk(24, 4), mk(24, 4));
    rd(`REG_DARK_SHORTFALL, 16'h0000);
    img(2, mk(500, 5), adj(mk(500, 5), mk(24, 4), 0, 1));
    $display("test rolling shutter done");
    // Automatic off again: the stored level must no longer be used.
    wr(`REG_LEVEL_CORR_CTRL, 16'h0000);
    start_frame(3, 20, 0, mk(24, 4), mk(24, 4));
    img(2, mk(500, 5), mk(500, 5));
    $display("test automatic off done");
    final_report();
  end
  // ----------------------------------------------------------------
  // Watchdog: the sequence needs well under 5000 cycles.
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    $display("wrong value at %0t: sequence did not finish", $time);
    final_report();
  end
endmodule
`default_nettype wire
